// ===== hdl/sps_port.sv
// two-wire slave port and upper register map of a temperature monitor
// assumes the bus master drives the clock line; pins are open drain, low when enabled
//
// Contract
// - answer only own seven-bit address
// - enabled timeout abandons transfer after 25 ms
// - bit7 clock timeout, bit6 data timeout
// - pec only when master clocks it
// - pec is crc-8 poly x8+x2+x+1
// - start then address msb first, direction
// - matched address acknowledged on ninth clock
// - direction 0 write, 1 read
// - nine clocks per byte, stop ends
// - direction fixed until new start
// - writes one or two bytes, reads one
// - first written byte loads pointer
// - second byte stored at pointer
// - plain read uses existing pointer
// - read and write addresses may differ
// - write to 0F triggers one measurement
`timescale 1ns/10ps
`default_nettype none
`include "sps_regs.svh"
module sps_port
	import sps_pkg::*;
#(
	parameter bit          ALT_ADDR     = 1'b0,
	parameter int          TMO_CYCLES   = `SPS_TMO_CYCLES,
	parameter logic [7:0]  PART_ID      = 8'hA5,   // arbitrary value
	parameter logic [7:0]  MAKER_ID     = 8'h5A,   // arbitrary value
	parameter int          FIFO_DEPTH   = 16
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            serial_clock_pin,
	input  wire logic            serial_data_pin_in,
	output logic                 serial_data_pin_out,
	output logic                 serial_data_pin_oe,
	input  wire sps_core_s       core_values,
	output logic                 measure_pulse,
	output logic [7:0]           reg_fault_count_and_timeouts,
	output logic [7:0]           reg_config2,
	output logic [7:0]           reg_local_shutdown_limit,
	output logic [7:0]           reg_shutdown_hysteresis,
	output logic [7:0]           reg_remote2_shutdown_limit
);
	if (TMO_CYCLES < 2) begin : g_bad_tmo
		$error("timeout count too small");
	end
	localparam logic [6:0] MY_ADDR = ALT_ADDR ? `SPS_ADDR_ALT : `SPS_ADDR_MAIN;

	////////////////////////////////////////////////////////////////////////////
	// pin conditioning: three flops, change taken when second and third agree
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic       scl;              // filtered clock level
	logic       sda;              // filtered data level
	logic       scl_d;            // previous filtered clock
	logic       sda_d;            // previous filtered data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], serial_clock_pin};
			sda_sync <= {sda_sync[1:0], serial_data_pin_in};
		end
	end
	// accept a new level only when stage two and three agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl   <= 1'b1;
			sda   <= 1'b1;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			if (scl_sync[1] == scl_sync[2]) begin
				scl <= scl_sync[2];
			end
			if (sda_sync[1] == sda_sync[2]) begin
				sda <= sda_sync[2];
			end
			scl_d <= scl;
			sda_d <= sda;
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise   = scl && !scl_d;
	assign scl_fall   = !scl && scl_d;
	assign start_cond = scl && scl_d && sda_d && !sda;
	assign stop_cond  = scl && scl_d && !sda_d && sda;

	////////////////////////////////////////////////////////////////////////////
	// crc-8 helper, one bit at a time
	function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
		crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SPS_CRC_POLY : 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// timeouts: clock held low or data held low too long
	logic        tmo_expired;
	logic [31:0] scl_low_cnt;
	logic [31:0] sda_low_cnt;
	sps_state_e  state;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_low_cnt <= '0;
			sda_low_cnt <= '0;
		end else begin
			// counting only while a transfer is open; idle bus is no fault
			scl_low_cnt <= (scl || state == SPS_IDLE) ? '0 : scl_low_cnt + 1'b1;
			sda_low_cnt <= (sda || state == SPS_IDLE) ? '0 : sda_low_cnt + 1'b1;
		end
	end
	assign tmo_expired = (reg_fault_count_and_timeouts[`SPS_BIT_SCL_TMO] &&
	                      scl_low_cnt >= 32'(TMO_CYCLES)) ||
	                     (reg_fault_count_and_timeouts[`SPS_BIT_SDA_TMO] &&
	                      sda_low_cnt >= 32'(TMO_CYCLES));

	////////////////////////////////////////////////////////////////////////////
	// byte engine
	logic [3:0] bit_cnt;       // bits shifted in the current byte
	logic [7:0] shreg;         // receive or transmit shift register
	logic [1:0] byte_idx;      // data bytes seen in this write
	logic [7:0] crc;           // running pec
	logic       is_read;       // direction of the current operation
	logic       rd_done;       // data byte already sent, next is pec
	logic       drive_low;     // pull data line low
	logic       wr_push;
	sps_wr_s    wr_word;
	logic       fifo_ready;
	logic [7:0] pointer;
	logic [7:0] rd_value;

	// open drain: enable only when pulling low
	assign serial_data_pin_out = 1'b0;
	assign serial_data_pin_oe  = drive_low;

	// state, bit counting and shifting
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state     <= SPS_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			byte_idx  <= 2'h0;
			crc       <= 8'h00;
			is_read   <= 1'b0;
			rd_done   <= 1'b0;
			drive_low <= 1'b0;
			wr_push   <= 1'b0;
			wr_word   <= '0;
		end else begin
			wr_push <= 1'b0;
			if (tmo_expired || stop_cond) begin
				state     <= SPS_IDLE;
				drive_low <= 1'b0;
			end else if (start_cond) begin
				// a fresh start is the only way to change direction
				state    <= SPS_ADDR;
				bit_cnt  <= 4'h0;
				byte_idx <= 2'h0;
				crc      <= 8'h00;
				rd_done  <= 1'b0;
				drive_low <= 1'b0;
			end else begin
				case (state)
					SPS_IDLE, SPS_IGN: begin
						drive_low <= 1'b0;
					end
					SPS_ADDR, SPS_WRX: begin
						if (scl_rise) begin
							shreg   <= {shreg[6:0], sda};
							bit_cnt <= bit_cnt + 1'b1;
							crc     <= crc_bit(crc, sda);
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							if (state == SPS_ADDR) begin
								if (shreg[7:1] == MY_ADDR) begin
									is_read   <= shreg[0];
									drive_low <= 1'b1;
									state     <= SPS_WACK;
								end else begin
									state <= SPS_IGN;
								end
							end else if (byte_idx < 2'h2 && fifo_ready) begin
								// pointer, then data; a third byte is the pec
								wr_push   <= 1'b1;
								wr_word   <= '{is_ptr: byte_idx == 2'h0, data: shreg};
								byte_idx  <= byte_idx + 1'b1;
								drive_low <= 1'b1;
								state     <= SPS_WACK;
							end else if (byte_idx == 2'h2) begin
								// pec byte: ack only if the check came out clean
								drive_low <= crc == 8'h00;
								byte_idx  <= 2'h3;
								state     <= SPS_WACK;
							end else begin
								state <= SPS_IGN;
							end
						end
					end
					SPS_WACK: begin
						// end ack after ninth clock falls; a read then drives its first data bit
						if (scl_fall) begin
							if (is_read) begin
								state     <= SPS_TX;
								shreg     <= rd_done ? crc : rd_value;
								drive_low <= rd_done ? !crc[7] : !rd_value[7];
								bit_cnt   <= 4'h0;
							end else begin
								drive_low <= 1'b0;
								state     <= SPS_WRX;
							end
						end
					end
					SPS_TX: begin
						if (scl_rise) begin
							crc     <= crc_bit(crc, shreg[7]);
							bit_cnt <= bit_cnt + 1'b1;
						end else if (scl_fall) begin
							shreg <= {shreg[6:0], 1'b1};
							if (bit_cnt == 4'h8) begin
								drive_low <= 1'b0;
								state     <= SPS_MACK;
							end else begin
								drive_low <= !shreg[6];
							end
						end
					end
					SPS_MACK: begin
						if (scl_rise) begin
							// one data byte per read, then the pec if acked
							state   <= (!sda && !rd_done) ? SPS_WACK : SPS_IGN;
							rd_done <= 1'b1;
						end
					end
					default: begin
						state <= SPS_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// received bytes queue towards the register side
	logic    q_valid;
	sps_wr_s q_word;
	sps_fifo #(
		.WIDTH ($bits(sps_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (wr_push),
		.in_ready  (fifo_ready),
		.in_data   (wr_word),
		.out_valid (q_valid),
		.out_ready (1'b1),
		.out_data  (q_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] r2_shut_bank;
	logic [7:0] r2_uplim_hb;
	logic [7:0] r2_lolim_hb;
	logic [7:0] r2_ofs_hb;
	logic [7:0] r2_ofs_lb;
	logic [7:0] r2_uplim_lb;
	logic [7:0] r2_lolim_lb;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pointer                      <= 8'h00;  // undefined on the part
			measure_pulse                <= 1'b0;
			r2_shut_bank                 <= `SPS_RST_LIMIT85;
			reg_local_shutdown_limit     <= `SPS_RST_LIMIT85;
			reg_shutdown_hysteresis      <= `SPS_RST_HYST;
			reg_fault_count_and_timeouts <= `SPS_RST_FAULT_TMO;
			reg_config2                  <= `SPS_RST_ZERO;
			r2_uplim_hb                  <= `SPS_RST_LIMIT85;
			r2_lolim_hb                  <= `SPS_RST_ZERO;
			r2_ofs_hb                    <= `SPS_RST_ZERO;
			r2_ofs_lb                    <= `SPS_RST_ZERO;
			r2_uplim_lb                  <= `SPS_RST_ZERO;
			r2_lolim_lb                  <= `SPS_RST_ZERO;
			reg_remote2_shutdown_limit   <= `SPS_RST_LIMIT85;
		end else begin
			measure_pulse <= 1'b0;
			if (q_valid && q_word.is_ptr) begin
				pointer <= q_word.data;
			end else if (q_valid) begin
				case (pointer)
					`SPS_OFS_ONESHOT:      measure_pulse <= 1'b1;
					`SPS_OFS_R2_SHUT_BANK: r2_shut_bank <= q_word.data;
					`SPS_OFS_LOC_SHUT:     reg_local_shutdown_limit <= q_word.data;
					`SPS_OFS_HYST:         reg_shutdown_hysteresis <= q_word.data;
					`SPS_OFS_FAULT_TMO:    reg_fault_count_and_timeouts <= q_word.data;
					`SPS_OFS_CONFIG2:      reg_config2 <= q_word.data;
					`SPS_OFS_R2_UPLIM_HB:  r2_uplim_hb <= q_word.data;
					`SPS_OFS_R2_LOLIM_HB:  r2_lolim_hb <= q_word.data;
					`SPS_OFS_R2_OFS_HB:    r2_ofs_hb <= q_word.data;
					`SPS_OFS_R2_OFS_LB:    r2_ofs_lb <= q_word.data;
					`SPS_OFS_R2_UPLIM_LB:  r2_uplim_lb <= q_word.data;
					`SPS_OFS_R2_LOLIM_LB:  r2_lolim_lb <= q_word.data;
					`SPS_OFS_R2_SHUT:      reg_remote2_shutdown_limit <= q_word.data;
					default: begin
						// no writable register here: byte dropped
					end
				endcase
			end
		end
	end

	// read mux; the one-shot address has no read side
	always_comb begin
		case (pointer)
			`SPS_OFS_R2_SHUT_BANK: rd_value = r2_shut_bank;
			`SPS_OFS_LOC_SHUT:     rd_value = reg_local_shutdown_limit;
			`SPS_OFS_HYST:         rd_value = reg_shutdown_hysteresis;
			`SPS_OFS_FAULT_TMO:    rd_value = reg_fault_count_and_timeouts;
			`SPS_OFS_STATUS2:      rd_value = core_values.status2;
			`SPS_OFS_CONFIG2:      rd_value = reg_config2;
			`SPS_OFS_R2_TEMP_HB:   rd_value = core_values.temp_hb;
			`SPS_OFS_R2_UPLIM_HB:  rd_value = r2_uplim_hb;
			`SPS_OFS_R2_LOLIM_HB:  rd_value = r2_lolim_hb;
			`SPS_OFS_R2_TEMP_LB:   rd_value = core_values.temp_lb;
			`SPS_OFS_R2_OFS_HB:    rd_value = r2_ofs_hb;
			`SPS_OFS_R2_OFS_LB:    rd_value = r2_ofs_lb;
			`SPS_OFS_R2_UPLIM_LB:  rd_value = r2_uplim_lb;
			`SPS_OFS_R2_LOLIM_LB:  rd_value = r2_lolim_lb;
			`SPS_OFS_R2_SHUT:      rd_value = reg_remote2_shutdown_limit;
			`SPS_OFS_PART_ID:      rd_value = PART_ID;
			`SPS_OFS_MAKER_ID:     rd_value = MAKER_ID;
			default:               rd_value = 8'h00;
		endcase
	end
endmodule // sps_port
`default_nettype wire

// ===== hdl/sps_regs.svh
// register offsets, reset values and timing counts of the sensor register port
// assumes a 200 MHz core clock; included by the package user files only
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_ADDR_MAIN        7'h4C
`define SPS_ADDR_ALT         7'h4B
`define SPS_OFS_ONESHOT      8'h0F
`define SPS_OFS_R2_SHUT_BANK 8'h19
`define SPS_OFS_LOC_SHUT     8'h20
`define SPS_OFS_HYST         8'h21
`define SPS_OFS_FAULT_TMO    8'h22
`define SPS_OFS_STATUS2      8'h23
`define SPS_OFS_CONFIG2      8'h24
`define SPS_OFS_R2_TEMP_HB   8'h30
`define SPS_OFS_R2_UPLIM_HB  8'h31
`define SPS_OFS_R2_LOLIM_HB  8'h32
`define SPS_OFS_R2_TEMP_LB   8'h33
`define SPS_OFS_R2_OFS_HB    8'h34
`define SPS_OFS_R2_OFS_LB    8'h35
`define SPS_OFS_R2_UPLIM_LB  8'h36
`define SPS_OFS_R2_LOLIM_LB  8'h37
`define SPS_OFS_R2_SHUT      8'h39
`define SPS_OFS_PART_ID      8'h3D
`define SPS_OFS_MAKER_ID     8'h3E
`define SPS_RST_LIMIT85      8'h55
`define SPS_RST_HYST         8'h0A
`define SPS_RST_FAULT_TMO    8'h01
`define SPS_RST_ZERO         8'h00
`define SPS_BIT_SCL_TMO      7
`define SPS_BIT_SDA_TMO      6
`define SPS_CRC_POLY         8'h07
`define SPS_TMO_MS           25
`define SPS_CLK_MHZ          200
`define SPS_TMO_CYCLES       (`SPS_TMO_MS * 1000 * `SPS_CLK_MHZ)
`endif

// ===== hdl/sps_pkg.sv
// types shared by the sensor register port and its test side
// assumes nothing beyond a SystemVerilog compiler
package sps_pkg;
	// bus engine states
	typedef enum logic [2:0] {
		SPS_IDLE = 3'b000,
		SPS_ADDR = 3'b001,
		SPS_WACK = 3'b010,
		SPS_WRX  = 3'b011,
		SPS_TX   = 3'b100,
		SPS_MACK = 3'b101,
		SPS_IGN  = 3'b110
	} sps_state_e;
	// one received byte, pointer or data, as handed to the register side
	typedef struct packed {
		logic       is_ptr;
		logic [7:0] data;
	} sps_wr_s;
	// values the monitor core supplies for reading
	typedef struct packed {
		logic [7:0] status2;
		logic [7:0] temp_hb;
		logic [7:0] temp_lb;
	} sps_core_s;
endpackage

// ===== hdl/sps_fifo.sv
// small synchronous valid/ready fifo for received bus bytes
// assumes one clock and an active low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module sps_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];   // storage words
	logic [AW:0]      wr_ptr;        // write pointer with wrap bit
	logic [AW:0]      rd_ptr;        // read pointer with wrap bit
	logic             push;
	logic             pop;
	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	// storage write, no reset needed for data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
	// pointers with wrap bit; head word read straight from the storage flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
	assign out_data = mem[rd_ptr[AW-1:0]];
endmodule // sps_fifo
`default_nettype wire

// ===== verif/sps_port_chk.sv
// checker of the sensor register port pins and register outputs
// assumes bind onto sps_port; one clock domain
`timescale 1ns/10ps
`default_nettype none
module sps_port_chk #(
	parameter int TMO_CYCLES = 200
) (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       serial_clock_pin,
	input wire logic       serial_data_pin_in,
	input wire logic       serial_data_pin_out,
	input wire logic       serial_data_pin_oe,
	input wire logic       measure_pulse,
	input wire logic [7:0] reg_fault_count_and_timeouts,
	input wire logic [7:0] reg_config2,
	input wire logic [7:0] reg_local_shutdown_limit
);
	// margin covers pin filter and register latency
	localparam int LIM = TMO_CYCLES + 20;
	logic [23:0] scl_lo; // cycles clock line low
	logic [23:0] sda_lo; // cycles data line low
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	// low time counters, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) scl_lo <= '0;
		else if (serial_clock_pin) scl_lo <= '0;
		else if (scl_lo != '1) scl_lo <= scl_lo + 1'b1;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) sda_lo <= '0;
		else if (serial_data_pin_in) sda_lo <= '0;
		else if (sda_lo != '1) sda_lo <= sda_lo + 1'b1;
	end
	////////////////////////////////////////////////////////////
	sequence rel_s;
		$rose(reset_n);
	endsequence
	sequence quiet_s;
		!serial_data_pin_oe && !measure_pulse;
	endsequence
	sequence steady_s;
		((serial_data_pin_out == 1'b0) && $stable(serial_data_pin_oe)) [*8];
	endsequence
	sequence held_s;
		($stable(reg_local_shutdown_limit) && $stable(reg_config2)) [*4];
	endsequence
	oe_hold_a: assert property ($rose(serial_clock_pin) |-> steady_s)
		else $error("data pin moved while clock high");
	oe_rise_a: assert property ($rose(serial_data_pin_oe) |-> !serial_clock_pin)
		else $error("data driven while clock high");
	oe_fall_a: assert property ($fell(serial_data_pin_oe) |-> !serial_clock_pin)
		else $error("data released while clock high");
	pulse_one_a: assert property (measure_pulse |=> !measure_pulse)
		else $error("measure pulse too long");
	pulse_keep_a: assert property (measure_pulse |-> held_s)
		else $error("trigger write stored data");
	reset_idle_a: assert property (rel_s |-> quiet_s and (reg_fault_count_and_timeouts == 8'h01))
		else $error("bad state after reset");
	clk_tmo_a: assert property ((reg_fault_count_and_timeouts[7] && scl_lo > LIM) |-> !serial_data_pin_oe)
		else $error("clock timeout not taken");
	data_tmo_a: assert property ((reg_fault_count_and_timeouts[6] && sda_lo > LIM) |-> !serial_data_pin_oe)
		else $error("data timeout not taken");
endmodule // sps_port_chk
`default_nettype wire

// ===== verif/sps_master.sv
// behavioural two-wire bus master facing the port
// assumes a pull-up on the data wire; 12 clk bus phases
`timescale 1ns/10ps
`default_nettype none
module sps_master (
	input  wire logic clk,
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// idle bus at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// data moves only mid clock low phase
	task automatic bo(input logic b, output logic r);
		w(6);
		sda_low <= !b;
		w(6);
		scl <= 1'b1;
		w(12);
		r = sda;
		scl <= 1'b0;
	endtask
	// fresh start, falling data with clock high
	task automatic start();
		w(6);
		sda_low <= 1'b1;
		w(12);
		scl <= 1'b0;
	endtask
	// rising data with clock high
	task automatic stop();
		w(6);
		sda_low <= 1'b1;
		w(6);
		scl <= 1'b1;
		w(12);
		sda_low <= 1'b0;
		w(12);
	endtask
	// eight bits msb first, then the ninth clock
	task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bo(d[i], b);
			q[i] = b;
		end
		bo(last, ack);
	endtask
	// address a write then park the clock low in the ack
	task automatic hang(input int n);
		logic b;
		start();
		for (int i = 7; i >= 0; i--) bo(1'(8'h98 >> i), b);
		// release only mid low phase, never on the clock edge itself
		w(6);
		sda_low <= 1'b0;
		w(n);
	endtask
endmodule // sps_master
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench of the sensor register port
// assumes sps_pkg compiled first; master model drives the bus
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sps_pkg::*;
	localparam logic [7:0] AW = 8'h98; // own address, write
	localparam logic [7:0] AR = 8'h99; // own address, read
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	wire logic  scl;
	wire logic  sda_low;
	wire logic  sda;
	logic       oe;
	logic       pulse;
	logic       a;
	logic       k;
	logic [7:0] q;
	logic [7:0] c;
	logic [7:0] rf;
	logic [7:0] rc;
	logic [7:0] rl;
	logic [7:0] rh;
	logic [7:0] rs;
	logic [7:0] pcnt = 8'h00;
	logic [7:0] ep = 8'h00;
	int         error_cnt = 0;
	int         checked = 0;
	sps_core_s  core = {8'h12, 8'h34, 8'h56};
	// pointer, data, expected read back
	logic [23:0] rows [18] = '{24'h203333, 24'h210707, 24'h24C3C3, 24'h194444, 24'h316666, 24'h322121,
		24'h349A9A, 24'h355C5C, 24'h36E1E1, 24'h371111, 24'h397777, 24'h23FF12, 24'h30FF34,
		24'h33FF56, 24'h3DFFA5, 24'h3EFF5A, 24'h0FFF00, 24'h50FF00};
	logic [15:0] dfl [12] = '{16'h1955, 16'h2055, 16'h210A, 16'h2201, 16'h2400, 16'h3155,
		16'h3200, 16'h3400, 16'h3500, 16'h3600, 16'h3700, 16'h3955};
	logic [7:0]  bad [4] = '{8'h96, 8'h9A, 8'h18, 8'h97};
	////////////////////////////////////////////////////////////
	// pull-up wire: low when either side pulls
	assign sda = ~(sda_low | oe);
	always #2.5 clk = ~clk;
	// count trigger pulses seen
	always @(posedge clk) if (pulse) pcnt <= pcnt + 8'h01;
	// timeout well above the longest low run of a normal transfer (about 9 bus bits)
	sps_port #(.TMO_CYCLES(1000), .PART_ID(8'hA5), .MAKER_ID(8'h5A)) uut (.clk(clk), .reset_n(reset_n),
		.serial_clock_pin(scl), .serial_data_pin_in(sda), .serial_data_pin_out(), .serial_data_pin_oe(oe),
		.core_values(core), .measure_pulse(pulse), .reg_fault_count_and_timeouts(rf),
		.reg_config2(rc), .reg_local_shutdown_limit(rl), .reg_shutdown_hysteresis(rh),
		.reg_remote2_shutdown_limit(rs));
	sps_master m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [7:0] crc(input logic [7:0] s, input logic [7:0] d);
		logic [7:0] x;
		x = s ^ d;
		for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
		return x;
	endfunction
	// pointer write, optional data byte
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic two);
		logic [7:0] r;
		logic a0, a1, a2;
		m.start();
		m.xb(AW, 1'b1, r, a0);
		m.xb(p, 1'b1, r, a1);
		a2 = 1'b0;
		if (two) m.xb(d, 1'b1, r, a2);
		m.stop();
		chk({5'h00, a0, a1, a2}, 8'h00);
	endtask
	// one byte read, master nacks it
	task automatic rd(output logic [7:0] d);
		logic a0, k0;
		m.start();
		m.xb(AR, 1'b1, d, a0);
		m.xb(8'hFF, 1'b1, d, k0);
		m.stop();
		chk({7'h00, a0}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8], 1'b1);
			if (rows[i][23:16] == 8'h0F) ep = ep + 8'h01;
			rd(q);
			chk(q, rows[i][7:0]);
			chk(pcnt, ep);
		end
		chk(rl, 8'h33);
		chk(rh, 8'h07);
		chk(rc, 8'hC3);
		chk(rs, 8'h77);
		// second reset in mid-run
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(rf, 8'h01);
		chk(rl, 8'h55);
		chk(rh, 8'h0A);
		chk(rs, 8'h55);
		chk(rc, 8'h00);
		rd(q);
		chk(q, 8'h00);
		foreach (dfl[i]) begin
			wr(dfl[i][15:8], 8'h00, 1'b0);
			rd(q);
			chk(q, dfl[i][7:0]);
		end
		rd(q);
		chk(q, 8'h55);
		// timeouts off: ack stays through a long low clock
		m.hang(1200);
		chk({7'h00, oe}, 8'h01);
		m.bo(1'b1, k);
		m.stop();
		foreach (bad[i]) begin
			m.start();
			m.xb(bad[i], 1'b1, q, a);
			m.stop();
			chk({7'h00, a}, 8'h01);
		end
		// checked write, good then corrupted check byte
		c = crc(crc(crc(8'h00, AW), 8'h20), 8'h5A);
		for (int j = 0; j < 2; j++) begin
			m.start();
			m.xb(AW, 1'b1, q, a);
			m.xb(8'h20, 1'b1, q, a);
			m.xb(8'h5A, 1'b1, q, a);
			m.xb(c ^ 8'(j), 1'b1, q, a);
			m.stop();
			chk({7'h00, a}, 8'(j));
		end
		// checked read: master acks the data byte
		m.start();
		m.xb(AR, 1'b1, q, a);
		m.xb(8'hFF, 1'b0, q, a);
		m.xb(8'hFF, 1'b1, c, a);
		m.stop();
		chk(q, 8'h5A);
		chk(c, crc(crc(8'h00, AR), 8'h5A));
		for (int j = 0; j < 2; j++) begin
			wr(8'h22, (j == 0) ? 8'h80 : 8'h40, 1'b1);
			m.hang(1200);
			chk({7'h00, oe}, 8'h00);
			m.bo(1'b1, k);
			m.stop();
		end
		wr(8'h22, 8'h01, 1'b1);
		rd(q);
		chk(q, 8'h01);
		finish_test();
	end
	// hang guard, well above the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule // tb
bind sps_port sps_port_chk #(.TMO_CYCLES(TMO_CYCLES)) chk_i (.clk(clk), .reset_n(reset_n),
	.serial_clock_pin(serial_clock_pin), .serial_data_pin_in(serial_data_pin_in),
	.serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
	.measure_pulse(measure_pulse), .reg_fault_count_and_timeouts(reg_fault_count_and_timeouts),
	.reg_config2(reg_config2), .reg_local_shutdown_limit(reg_local_shutdown_limit));
`default_nettype wire
